// File: pfeu_pkg.sv
// Functional notes
// RL1 - System reset request bit 2 resets system except debug logic. Code shows this request at reset_ctrl_out bit 1.
// RL2 - Core-only reset bit 0 resets just the processor.
// RL3 - Dedicated fault handlers dispatch only when their enable bits are set.
// RL4 - Use fault without enabled handler escalates to escalated fault.
// RL5 - Cache maintenance bus errors are reported asynchronous and imprecise.
// RL6 - Imprecise cache bus error never escalates when enabled, never locks up.
// RL7 - Software follows cache maintenance with a data sync barrier.
// RL8 - Uncorrectable cache ECC error raises a bus error fault.
// RL9 - Strongly ordered write bus error may report imprecise.
// RL10 - Entry may start before write buffer drains; stacked pc may differ.
// RL11 - Entry stacks r0-r3, r12, pc, lr on active stack.
// RL12 - Link register gets a return code naming the saved-frame stack.
// RL13 - Return code bit 2 clear for main stack, set for process stack.
// RL14 - Stacked pc is faulting instruction if incomplete, else next one.
// RL15 - Unsupported opcode raises use fault with undefined opcode flag.
// RL16 - Branch with state bit clear raises use fault with invalid state flag.
// RL17 - Divide by zero with trapping raises use fault with zero divisor flag.
// RL18 - Use fault flags stay set until written one or reset.
// RL19 - Divide trapping active only when trap enable bit is one.
// RL20 - Reset request bits self-clear after the reset takes effect.
package pfeu_pkg;
    localparam int SYS_RESET_BIT = 2;
    localparam int CORE_RESET_BIT = 0;
    localparam int RET_STACK_BIT = 2;
    localparam logic [31:0] RET_CODE_BASE = 32'hFFFFFFF9;
    localparam int FRAME_WORDS = 7;
    localparam int RESET_PULSE_CYCLES = 4;
    localparam int FLAG_UNDEF = 0;
    localparam int FLAG_INVALID_STATE_FLAG = 1;
    localparam int FLAG_ZDIV = 2;
    typedef enum logic [2:0] {
        PFEU_NONE,
        PFEU_PROT,
        PFEU_BUS,
        PFEU_USE,
        PFEU_ESCAL
    } pfeu_exc_t;
    typedef enum logic [1:0] {
        PFEU_IDLE,
        PFEU_STACK,
        PFEU_DONE
    } pfeu_state_t;
endpackage

// File: pfeu_reset_pulse.sv
`timescale 1ns/1ns
module pfeu_reset_pulse #(
    parameter int CYCLES = pfeu_pkg::RESET_PULSE_CYCLES
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic ce_in,
    input wire logic req_in,
    output logic rst_out,
    output logic busy_out
);
    logic [7:0] cnt_reg;
    wire active = (cnt_reg != 8'h00);
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            cnt_reg <= 8'h00;
            rst_out <= 1'b0;
        end else if (ce_in) begin
            if (req_in && !active) begin
                cnt_reg <= 8'(CYCLES);
            end else if (active) begin
                cnt_reg <= cnt_reg - 8'h01;
            end
            rst_out <= (req_in && !active) || (cnt_reg > 8'h01);
        end
    end
    assign busy_out = active;
endmodule // pfeu_reset_pulse

// File: pfeu_top.sv
`timescale 1ns/1ns
module pfeu_top (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic ce_in,
    input wire logic sys_reset_req_in,
    input wire logic core_reset_req_in,
    input wire logic protection_handler_enable_in,
    input wire logic bus_error_handler_enable_in,
    input wire logic use_fault_handler_enable_in,
    input wire logic zero_divisor_trap_enable_in,
    input wire logic prot_violation_in,
    input wire logic bus_error_precise_in,
    input wire logic bus_error_so_write_in,
    input wire logic cache_maint_error_in,
    input wire logic ecc_uncorrectable_in,
    input wire logic undefined_opcode_in,
    input wire logic branch_state_clear_in,
    input wire logic divide_zero_in,
    input wire logic instr_completed_in,
    input wire logic [31:0] fault_pc_in,
    input wire logic [31:0] next_pc_in,
    input wire logic process_stack_active_in,
    input wire logic [31:0] main_stack_pointer_in,
    input wire logic [31:0] process_stack_pointer_in,
    input wire logic [31:0] gpr_in [0:4],
    input wire logic [31:0] lr_in,
    input wire logic [2:0] flag_clear_in,
    input wire logic frame_ack_in,
    output logic system_reset_out,
    output logic core_reset_out,
    output logic [1:0] reset_ctrl_out,
    output logic [2:0] exc_out,
    output logic exc_valid_out,
    output logic bus_imprecise_out,
    output logic [2:0] use_flags_out,
    output logic frame_we_out,
    output logic [31:0] frame_addr_out,
    output logic [31:0] frame_data_out,
    output logic [31:0] exception_return_code_out,
    output logic entry_done_out
);
    // ----------------------------------------
    // Reset requests
    // ----------------------------------------
    logic sys_busy;
    logic core_busy;
    logic sys_rst_pulse;
    logic core_rst_pulse;
    pfeu_reset_pulse u_sys_pulse (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .ce_in(ce_in),
        .req_in(sys_reset_req_in),
        .rst_out(sys_rst_pulse),
        .busy_out(sys_busy)
    ); // [RL1]
    pfeu_reset_pulse u_core_pulse (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .ce_in(ce_in),
        .req_in(core_reset_req_in),
        .rst_out(core_rst_pulse),
        .busy_out(core_busy)
    ); // [RL2]
    // Core-only reset also clears fault state, but debug logic is never touched here
    wire core_clear = sys_rst_pulse || core_rst_pulse;
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            system_reset_out <= 1'b0;
            core_reset_out <= 1'b0;
            reset_ctrl_out <= 2'b00;
        end else if (ce_in) begin
            system_reset_out <= sys_rst_pulse; // [RL1]
            core_reset_out <= core_rst_pulse && !sys_rst_pulse; // [RL2]
            reset_ctrl_out <= {sys_busy, core_busy}; // [RL20]
        end
    end

    // ----------------------------------------
    // Fault classification
    // ----------------------------------------
    wire zdiv_fault = divide_zero_in && zero_divisor_trap_enable_in; // [RL17] [RL19]
    wire use_fault = undefined_opcode_in || branch_state_clear_in || zdiv_fault; // [RL15] [RL16]
    // Cache maintenance, ECC and strongly ordered writes all land as imprecise bus errors
    wire bus_imprecise = cache_maint_error_in || ecc_uncorrectable_in || bus_error_so_write_in; // [RL5] [RL8] [RL9]
    wire bus_fault = bus_error_precise_in || bus_imprecise; // [RL8]
    wire any_fault = prot_violation_in || bus_fault || use_fault;
    wire [2:0] flag_set = {zdiv_fault, branch_state_clear_in, undefined_opcode_in};

    // Priority: protection, then bus, then use; disabled handler escalates
    wire [2:0] exc_sel =
        prot_violation_in ? (protection_handler_enable_in ? 3'(pfeu_pkg::PFEU_PROT) : 3'(pfeu_pkg::PFEU_ESCAL)) :
        bus_fault ? (bus_error_handler_enable_in ? 3'(pfeu_pkg::PFEU_BUS) : 3'(pfeu_pkg::PFEU_ESCAL)) :
        use_fault ? (use_fault_handler_enable_in ? 3'(pfeu_pkg::PFEU_USE) : 3'(pfeu_pkg::PFEU_ESCAL)) :
        3'(pfeu_pkg::PFEU_NONE); // [RL3] [RL4] [RL6]

    // ----------------------------------------
    // Sticky use fault flags
    // ----------------------------------------
    logic [2:0] flags_reg;
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            flags_reg <= 3'h0;
        end else if (ce_in) begin
            if (core_clear) begin
                flags_reg <= 3'h0;
            end else begin
                // Set wins over a simultaneous write-one clear
                flags_reg <= (flags_reg & ~flag_clear_in) | flag_set; // [RL18]
            end
        end
    end
    assign use_flags_out = flags_reg;

    // ----------------------------------------
    // Exception entry and stacking
    // ----------------------------------------
    pfeu_pkg::pfeu_state_t state_reg;
    logic [2:0] idx_reg;
    logic [31:0] frame_reg [0:pfeu_pkg::FRAME_WORDS-1];
    logic [31:0] sp_reg;
    logic psp_reg;
    wire idle = (state_reg == pfeu_pkg::PFEU_IDLE);
    wire take = idle && any_fault && !core_clear;
    // Return address: faulting instruction unless it completed
    wire [31:0] ret_pc = instr_completed_in ? next_pc_in : fault_pc_in; // [RL14]
    wire [31:0] entry_sp = process_stack_active_in ? process_stack_pointer_in : main_stack_pointer_in; // [RL11]
    wire [31:0] ret_code = {pfeu_pkg::RET_CODE_BASE[31:pfeu_pkg::RET_STACK_BIT+1],
        process_stack_active_in, pfeu_pkg::RET_CODE_BASE[pfeu_pkg::RET_STACK_BIT-1:0]}; // [RL12] [RL13]
    wire last_word = (idx_reg == 3'(pfeu_pkg::FRAME_WORDS - 1));
    wire [31:0] word_addr = sp_reg - 32'(({29'h0, idx_reg} + 32'h1) << 2);

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            state_reg <= pfeu_pkg::PFEU_IDLE;
            idx_reg <= 3'h0;
            sp_reg <= 32'h0;
            psp_reg <= 1'b0;
            exc_out <= 3'h0;
            exc_valid_out <= 1'b0;
            bus_imprecise_out <= 1'b0;
            exception_return_code_out <= 32'h0;
            entry_done_out <= 1'b0;
            frame_we_out <= 1'b0;
            frame_addr_out <= 32'h0;
            frame_data_out <= 32'h0;
            for (int i = 0; i < pfeu_pkg::FRAME_WORDS; i++) begin
                frame_reg[i] <= 32'h0;
            end
        end else if (ce_in) begin
            exc_valid_out <= 1'b0;
            entry_done_out <= 1'b0;
            frame_we_out <= 1'b0;
            if (core_clear) begin
                state_reg <= pfeu_pkg::PFEU_IDLE;
                idx_reg <= 3'h0;
            end else begin
                case (state_reg)
                    pfeu_pkg::PFEU_IDLE: begin
                        if (take) begin
                            // Entry does not wait for buffered writes to drain
                            // so an imprecise error may stack a later context's pc
                            for (int i = 0; i < 5; i++) begin
                                frame_reg[i] <= gpr_in[i];
                            end // [RL11] [RL10]
                            frame_reg[5] <= ret_pc; // [RL14]
                            frame_reg[6] <= lr_in; // [RL11]
                            sp_reg <= entry_sp;
                            psp_reg <= process_stack_active_in;
                            exc_out <= exc_sel; // [RL3] [RL4]
                            exc_valid_out <= 1'b1;
                            bus_imprecise_out <= bus_imprecise && !prot_violation_in; // [RL5]
                            exception_return_code_out <= ret_code; // [RL12]
                            idx_reg <= 3'h0;
                            state_reg <= pfeu_pkg::PFEU_STACK;
                        end
                    end
                    pfeu_pkg::PFEU_STACK: begin
                        frame_we_out <= 1'b1;
                        frame_addr_out <= word_addr; // [RL11]
                        frame_data_out <= frame_reg[idx_reg];
                        if (frame_we_out && frame_ack_in) begin
                            frame_we_out <= 1'b0;
                            if (last_word) begin
                                state_reg <= pfeu_pkg::PFEU_DONE;
                            end else begin
                                idx_reg <= idx_reg + 3'h1;
                            end
                        end
                    end
                    pfeu_pkg::PFEU_DONE: begin
                        // No lockup path: always returns to idle
                        entry_done_out <= 1'b1; // [RL6]
                        state_reg <= pfeu_pkg::PFEU_IDLE;
                    end
                    default: begin
                        state_reg <= pfeu_pkg::PFEU_IDLE;
                    end
                endcase
            end
        end
    end
    // Software is expected to barrier after cache maintenance; nothing here waits on it
endmodule // pfeu_top

// File: pfeu_top_asserts.sv
`timescale 1ns/1ns
module pfeu_top_asserts (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic sys_reset_req_in,
    input wire logic prot_violation_in,
    input wire logic protection_handler_enable_in,
    input wire logic cache_maint_error_in,
    input wire logic bus_error_handler_enable_in,
    input wire logic undefined_opcode_in,
    input wire logic use_fault_handler_enable_in,
    input wire logic process_stack_active_in,
    input wire logic [31:0] main_stack_pointer_in,
    input wire logic [31:0] process_stack_pointer_in,
    input wire logic [2:0] flag_clear_in,
    input wire logic system_reset_out,
    input wire logic core_reset_out,
    input wire logic [1:0] reset_ctrl_out,
    input wire logic [2:0] exc_out,
    input wire logic exc_valid_out,
    input wire logic bus_imprecise_out,
    input wire logic [2:0] use_flags_out,
    input wire logic frame_we_out,
    input wire logic [31:0] frame_addr_out,
    input wire logic [31:0] exception_return_code_out,
    input wire logic entry_done_out
);
    logic busy_reg;
    wire logic take_ok = !busy_reg && !exc_valid_out && !system_reset_out && !core_reset_out;
    wire logic [31:0] sp_sel = process_stack_active_in ? process_stack_pointer_in : main_stack_pointer_in;
    // ----------------------------------------
    // Entry tracking, faults are refused while stacking
    // ----------------------------------------
    always_ff @(posedge clk_in) begin
        if (sys_rst_in || system_reset_out || core_reset_out || entry_done_out) begin
            busy_reg <= 1'b0;
        end else if (exc_valid_out) begin
            busy_reg <= 1'b1;
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    prot_dispatch_a: assert property (
        take_ok && prot_violation_in && protection_handler_enable_in |=> exc_valid_out && exc_out == 3'h1)
        else $error("protection fault not dispatched");
    use_escalate_a: assert property (
        take_ok && undefined_opcode_in && !prot_violation_in && !bus_error_handler_enable_in
        && !use_fault_handler_enable_in |=> exc_out == 3'h4)
        else $error("use fault not escalated");
    cache_imprecise_a: assert property (
        take_ok && cache_maint_error_in && !prot_violation_in && bus_error_handler_enable_in
        |=> exc_out == 3'h2 && bus_imprecise_out) else $error("cache bus error not imprecise");
    ret_code_a: assert property (
        exc_valid_out |-> exception_return_code_out == (pfeu_pkg::RET_CODE_BASE | {29'h0, $past(process_stack_active_in), 2'h0}))
        else $error("return code wrong");
    frame_start_a: assert property (
        exc_valid_out |=> frame_we_out && frame_addr_out == $past(sp_sel, 2) - 32'h4) else $error("first frame word wrong");
    sys_pulse_a: assert property (
        $rose(sys_reset_req_in) && !reset_ctrl_out[1] |-> ##[1:2] $rose(system_reset_out) ##0 system_reset_out [*4]
        ##1 !system_reset_out) else $error("system reset pulse wrong");
    req_selfclear_a: assert property (
        $rose(reset_ctrl_out[1]) |-> ##[1:8] !reset_ctrl_out[1]) else $error("reset request not cleared");
    sticky_flags_a: assert property (
        !system_reset_out && !core_reset_out |-> &(use_flags_out | ~$past(use_flags_out & ~flag_clear_in)))
        else $error("use flag lost");
    cover property (take_ok && prot_violation_in);
    cover property ($rose(system_reset_out));
    cover property (entry_done_out);
endmodule // pfeu_top_asserts
bind pfeu_top pfeu_top_asserts i_pfeu_top_asserts (.*);

// File: pfeu_top_bench.sv
`timescale 1ns/1ns
module pfeu_top_bench;
    logic clk_in = 1'b0, sys_rst_in = 1'b1, ce_in = 1'b1, sys_reset_req_in = 1'b0, core_reset_req_in = 1'b0;
    logic zero_divisor_trap_enable_in = 1'b0, instr_completed_in = 1'b0, process_stack_active_in = 1'b0;
    logic frame_ack_in = 1'b0, system_reset_out, core_reset_out, exc_valid_out, bus_imprecise_out;
    logic frame_we_out, entry_done_out;
    logic [7:0] ev = 8'h00;
    logic [2:0] en = 3'h0, flag_clear_in = 3'h0, exc_out, use_flags_out;
    logic [1:0] reset_ctrl_out;
    logic [31:0] fault_pc_in = 32'h0000_0248, next_pc_in = 32'h0000_024C, lr_in = 32'h0000_0311;
    logic [31:0] main_stack_pointer_in = 32'h2000_1050, process_stack_pointer_in = 32'h2000_0800;
    logic [31:0] frame_addr_out, frame_data_out, exception_return_code_out;
    logic [31:0] gpr_in [0:4];
    logic [31:0] words [0:6];
    logic [31:0] addrs [0:6];
    logic prot_violation_in, bus_error_precise_in, bus_error_so_write_in, cache_maint_error_in;
    logic ecc_uncorrectable_in, undefined_opcode_in, branch_state_clear_in, divide_zero_in;
    logic protection_handler_enable_in, bus_error_handler_enable_in, use_fault_handler_enable_in;
    int error_cnt = 0, n_tests = 0, wi = 0, cyc = 0;
    assign {divide_zero_in, branch_state_clear_in, undefined_opcode_in, ecc_uncorrectable_in} = ev[7:4];
    assign {cache_maint_error_in, bus_error_so_write_in, bus_error_precise_in, prot_violation_in} = ev[3:0];
    assign {use_fault_handler_enable_in, bus_error_handler_enable_in, protection_handler_enable_in} = en;
    pfeu_top i_pfeu_top (.*);
    initial forever #10 clk_in = ~clk_in;
    // Memory side accepts every frame word one cycle after it is offered
    always @(negedge clk_in) frame_ack_in <= frame_we_out;
    always @(posedge clk_in) begin
        cyc++;
        if (frame_we_out && frame_ack_in) begin
            words[wi % 7] = frame_data_out;
            addrs[wi % 7] = frame_addr_out;
            wi++;
        end
        if (cyc == 3000) begin
            error_cnt++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("tests %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic take(input logic [7:0] e, input logic ps, input logic cmp, input logic [2:0] x, input logic imp);
        logic [31:0] sp;
        sp = ps ? process_stack_pointer_in : main_stack_pointer_in;
        wi = 0;
        ev = e;
        process_stack_active_in = ps;
        instr_completed_in = cmp;
        @(negedge clk_in);
        ev = 8'h00;
        chk(exc_valid_out, 1'b1, "valid");
        chk(exc_out, x, "class");
        chk(bus_imprecise_out, imp, "imprecise");
        chk(exception_return_code_out, pfeu_pkg::RET_CODE_BASE | {29'h0, ps, 2'h0}, "ret code");
        repeat (60) if (entry_done_out !== 1'b1) @(negedge clk_in);
        chk(entry_done_out, 1'b1, "done");
        for (int i = 0; i < 7; i++) begin
            chk(words[i], i < 5 ? gpr_in[i % 5] : i == 5 ? (cmp ? next_pc_in : fault_pc_in) : lr_in, "word");
            chk(addrs[i], sp - 32'h4 * (i + 1), "addr");
        end
        @(negedge clk_in);
    endtask
    task automatic rreq(input logic s);
        int hi;
        int lo;
        hi = 0;
        lo = 0;
        {sys_reset_req_in, core_reset_req_in} = {s, !s};
        @(negedge clk_in);
        {sys_reset_req_in, core_reset_req_in} = 2'h0;
        repeat (12) begin
            @(negedge clk_in);
            hi += int'(s ? system_reset_out : core_reset_out);
            lo += int'((s ? core_reset_out : system_reset_out) !== 1'b0);
        end
        chk(hi, pfeu_pkg::RESET_PULSE_CYCLES, "pulse");
        chk(lo, 0, "other reset");
        chk(reset_ctrl_out, 2'h0, "self clear");
        chk(use_flags_out, 3'h0, "flags reset");
    endtask
    initial begin
        foreach (gpr_in[i]) gpr_in[i] = 32'h0000_0100 + i;
        repeat (20) @(negedge clk_in);
        sys_rst_in = 1'b0;
        @(negedge clk_in);
        chk({exc_out, use_flags_out, reset_ctrl_out}, 8'h00, "after reset");
        take(8'h20, 1'b0, 1'b0, 3'h4, 1'b0);
        chk(use_flags_out, 3'h1, "undef");
        en = 3'h7;
        take(8'h40, 1'b1, 1'b1, 3'h3, 1'b0);
        chk(use_flags_out, 3'h3, "invalid_state_flag");
        ev = 8'h80;
        @(negedge clk_in);
        ev = 8'h00;
        repeat (30) @(negedge clk_in);
        chk(use_flags_out, 3'h3, "no trap");
        zero_divisor_trap_enable_in = 1'b1;
        take(8'h80, 1'b0, 1'b0, 3'h3, 1'b0);
        chk(use_flags_out, 3'h7, "zdiv");
        flag_clear_in = 3'h5;
        @(negedge clk_in);
        flag_clear_in = 3'h0;
        chk(use_flags_out, 3'h2, "w1c");
        take(8'h01, 1'b0, 1'b0, 3'h1, 1'b0);
        take(8'h02, 1'b1, 1'b0, 3'h2, 1'b0);
        take(8'h08, 1'b0, 1'b1, 3'h2, 1'b1);
        take(8'h10, 1'b0, 1'b0, 3'h2, 1'b1);
        take(8'h04, 1'b1, 1'b0, 3'h2, 1'b1);
        rreq(1'b1);
        take(8'h20, 1'b0, 1'b1, 3'h3, 1'b0);
        rreq(1'b0);
        complete_run();
    end
endmodule // pfeu_top_bench
